//--- bench/ctrl_model.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------
// controller model
// ----------------
module ctrl_model
    import bank_tracker_pkg::*;
(
    input  wire logic clk_sys,
    output logic       clk_en,
    output logic       cmd_valid,
    output sdram_cmd_t cmd,
    output logic       burst_done
);
    // quiet bus at time zero
    initial begin
        clk_en     = 1'b0;
        cmd_valid  = 1'b0;
        cmd        = '0;
        burst_done = 1'b0;
    end
    // clock enable level
    task automatic cke(input logic v);
        @(negedge clk_sys);
        clk_en = v;
    endtask
    // one command for one cycle, then no-operation
    // bank 2 and plain access unless the caller says otherwise
    task automatic send(input cmd_code_t c, input int b = 2,
                        input logic ap = 1'b0, input logic rw = 1'b0);
        @(negedge clk_sys);
        cmd_valid = 1'b1;
        cmd       = '{c, 3'(b), ap, rw};
        @(negedge clk_sys);
        cmd_valid = 1'b0;
        cmd.code  = CMD_NOP;
    endtask
    // nop cycles, used until timed states end
    // reset and refresh commands follow idle only, register write also power-on and resetting
    task automatic nops(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    // natural end of a burst, before a direction change
    task automatic burst_end();
        @(negedge clk_sys);
        burst_done = 1'b1;
        @(negedge clk_sys);
        burst_done = 1'b0;
    endtask
endmodule
`default_nettype wire

//--- bench/testbench.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------
// scenario bench
// ----------------
module testbench
    import bank_tracker_pkg::*;
;
    logic           clk_sys, reset, clk_en, cmd_valid, burst_done;
    sdram_cmd_t     cmd;
    logic [71:0]    bank_states;
    dev_state_t     dev_state;
    logic           all_idle, cmd_illegal;
    logic           ill_seen = 1'b0;
    int             fail_count = 0;
    int             tests_run = 0;
    int             cycles = 0;

    sdram_bank_state_tracker #(.NUM_BANKS(8), .CNT_W(8)) DUT (
        .clk_sys, .reset, .clk_en, .cmd_valid, .cmd, .burst_done,
        .bank_states, .dev_state, .all_idle, .cmd_illegal
    );
    ctrl_model P (.clk_sys, .clk_en, .cmd_valid, .cmd, .burst_done);

    // clock, timeout and breach capture
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cycles++;
        if (cmd_illegal === 1'b1) ill_seen = 1'b1;
        if (cycles == 4000) begin
            fail_count++;
            stop_test();
        end
    end

    function automatic logic [8:0] cur(input int s);
        return (s < 0) ? {1'b0, dev_state} : bank_states[s*9 +: 9];
    endfunction
    task automatic note(input bit bad, input string m);
        tests_run++;
        if (bad) begin
            fail_count++;
            $display("mismatch at %0t: %s", $time, m);
        end
    endtask
    task automatic cmp_st(input logic [8:0] g, input logic [8:0] e);
        note(g !== e, $sformatf("state %h not %h", g, e));
    endtask
    task automatic cmp_n(input int g, input int e);
        note(g != e, $sformatf("%0d cycles not %0d", g, e));
    endtask
    task automatic cmp_flag(input logic g, input logic e);
        note(g !== e, $sformatf("flag %b not %b", g, e));
    endtask
    // wait bounded for a state, then compare
    task automatic expect_st(input int s, input logic [8:0] st);
        int w;
        w = 0;
        while (cur(s) !== st && w < 8) begin
            @(negedge clk_sys);
            w++;
        end
        cmp_st(cur(s), st);
    endtask
    // cycles a state lasts once it appears
    task automatic span(input int s, input logic [8:0] st, output int n);
        int w;
        w = 0;
        n = 0;
        while (cur(s) !== st && w < 8) begin
            @(negedge clk_sys);
            w++;
        end
        while (cur(s) === st && n < 20) begin
            @(negedge clk_sys);
            n++;
        end
    endtask
    task automatic recover();
        int n;
        P.send(CMD_MR_READ, 0);
        span(-1, DS_RESET_MRR, n);
        cmp_n(n, 2);
        cmp_st(cur(-1), DS_BANKS);
        P.nops(2);
        cmp_flag(all_idle, 1'b1);
    endtask
    task automatic t_init();
        P.cke(1'b1);
        P.nops(8);
        P.send(CMD_MR_WRITE, 0, 1'b0, 1'b1);
        expect_st(-1, DS_RESETTING);
        recover();
    endtask
    task automatic t_activate();
        int n;
        P.send(CMD_ACTIVATE);
        span(2, BS_ACTIVATING, n);
        cmp_n(n, 1);
        cmp_st(cur(2), BS_ACTIVE);
        cmp_st(cur(3), BS_IDLE);
        cmp_flag(all_idle, 1'b0);
        P.send(CMD_MR_READ);
        span(2, BS_ACT_MRR, n);
        cmp_n(n, 2);
        cmp_st(cur(2), BS_ACTIVE);
    endtask
    task automatic t_bursts();
        P.send(CMD_READ);
        expect_st(2, BS_READING);
        P.send(CMD_READ);
        P.send(CMD_BURST_TERM, 5);
        expect_st(2, BS_ACTIVE);
        P.send(CMD_WRITE);
        expect_st(2, BS_WRITING);
        P.burst_end();
        expect_st(2, BS_ACTIVE);
        P.send(CMD_WRITE);
        expect_st(2, BS_WRITING);
        P.nops(4);
        cmp_flag(ill_seen, 1'b0);
        // breach is flagged, the read still opens its burst
        P.send(CMD_READ);
        P.nops(6);
        cmp_flag(ill_seen, 1'b1);
        cmp_st(cur(2), BS_READING);
        P.send(CMD_BURST_TERM);
        expect_st(2, BS_ACTIVE);
    endtask
    task automatic t_auto_pre();
        int n;
        for (int i = 0; i < 2; i++) begin
            if (i == 1) P.send(CMD_ACTIVATE);
            expect_st(2, BS_ACTIVE);
            P.send(i ? CMD_WRITE : CMD_READ, 2, 1'b1);
            span(2, BS_AUTO_PRE, n);
            cmp_n(n, 1);
            cmp_st(cur(2), BS_IDLE);
        end
    endtask
    task automatic t_precharge();
        int n;
        for (int i = 0; i < 2; i++) begin
            if (i == 1) P.send(CMD_ACTIVATE);
            P.nops(4);
            P.send(CMD_PRECHARGE);
            span(2, BS_PRECHARGE, n);
            cmp_n(n, 1);
            cmp_st(cur(2), BS_IDLE);
        end
        P.send(CMD_REFRESH_PB);
        span(2, BS_REFRESH, n);
        cmp_n(n, 1);
        cmp_st(cur(2), BS_IDLE);
    endtask
    task automatic t_device();
        cmd_code_t  c[4] = '{CMD_REFRESH_AB, CMD_MR_WRITE, CMD_MR_READ,
                             CMD_PRECH_ALL};
        dev_state_t d[4] = '{DS_REFRESH_AB, DS_MR_WRITE, DS_IDLE_MRR,
                             DS_PRECH_ALL};
        int         len[4] = '{2, 5, 2, 1};
        int         n;
        for (int i = 0; i < 4; i++) begin
            if (i == 3) P.send(CMD_ACTIVATE);
            P.nops(4);
            P.send(c[i], 0);
            span(-1, d[i], n);
            cmp_n(n, len[i]);
            cmp_st(cur(-1), DS_BANKS);
            cmp_st(cur(2), BS_IDLE);
            P.nops(2);
            cmp_flag(all_idle, 1'b1);
        end
    endtask
    task automatic t_cke_reset();
        int n;
        P.cke(1'b0);
        P.nops(3);
        P.send(CMD_ACTIVATE);
        P.nops(5);
        P.cke(1'b1);
        P.nops(8);
        cmp_st(cur(2), BS_IDLE);
        P.send(CMD_RESET, 0);
        expect_st(-1, DS_RESETTING);
        recover();
        // reset-type mode write from idle, then a plain one while resetting
        P.send(CMD_MR_WRITE, 0, 1'b0, 1'b1);
        expect_st(-1, DS_RESETTING);
        P.send(CMD_MR_WRITE, 0);
        span(-1, DS_MR_WRITE, n);
        cmp_n(n, 5);
        cmp_st(cur(-1), DS_BANKS);
    endtask
    task automatic stop_test();
        $display("checks %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // reset, then the scenarios in order
    initial begin
        reset = 1'b1;
        repeat (5) @(posedge clk_sys);
        @(negedge clk_sys);
        reset = 1'b0;
        t_init();
        t_activate();
        t_bursts();
        t_auto_pre();
        t_precharge();
        t_device();
        t_cke_reset();
        stop_test();
    end
endmodule
`default_nettype wire

//--- bench/tracker_asserts.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------
// checker
// ----------------
module tracker_asserts
    import bank_tracker_pkg::*;
#(
    parameter int NUM_BANKS = 8,
    parameter int CNT_W     = 8
) (
    input wire logic                   clk_sys,
    input wire logic                   reset,
    input wire logic                   clk_en,
    input wire logic                   cmd_valid,
    input wire sdram_cmd_t             cmd,
    input wire logic                   burst_done,
    input wire logic [NUM_BANKS*9-1:0] bank_states,
    input wire dev_state_t             dev_state,
    input wire logic                   all_idle,
    input wire logic                   cmd_illegal
);
    logic       k1_ff, k2_ff, v1_ff, v2_ff, ok, mode_register_read, idle_all;
    sdram_cmd_t c1_ff, c2_ff;
    logic [3:0] run_ff;
    logic [8:0] b2;
    // copies aligned with the input synchroniser
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            k1_ff  <= 1'b0;
            k2_ff  <= 1'b0;
            v1_ff  <= 1'b0;
            v2_ff  <= 1'b0;
            c1_ff  <= '0;
            c2_ff  <= '0;
            run_ff <= 4'h0;
        end else begin
            k1_ff  <= clk_en;
            k2_ff  <= k1_ff;
            v1_ff  <= cmd_valid;
            v2_ff  <= v1_ff;
            c1_ff  <= cmd;
            c2_ff  <= c1_ff;
            run_ff <= !k2_ff ? 4'h0 : (&run_ff) ? run_ff : run_ff + 4'h1;
        end
    end
    // watched bank is bank 2
    assign b2       = bank_states[18 +: 9];
    assign ok       = v2_ff && k2_ff && (run_ff > 4'h6);
    assign mode_register_read      = dev_state == DS_IDLE_MRR || dev_state == DS_RESET_MRR;
    assign idle_all = bank_states == {NUM_BANKS{9'h001}};
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    a_act_opens_row: assert property (ok && c2_ff.code == CMD_ACTIVATE
        && c2_ff.bank == 3'h2 && b2 == BS_IDLE |=> ##[0:1] b2 == BS_ACTIVATING)
        else $error("activate did not open the row");
    a_cke_low_holds: assert property (v2_ff && !k2_ff && b2 == BS_IDLE
        && c2_ff.code == CMD_ACTIVATE |=> ##[0:1] b2 == BS_IDLE)
        else $error("command acted with clock enable low");
    a_row_open_ends: assert property ($rose(b2 == BS_ACTIVATING)
        |=> b2 == BS_ACTIVE) else $error("row activation length wrong");
    a_precharge_ends: assert property ($rose(b2 == BS_PRECHARGE)
        |=> b2 == BS_IDLE) else $error("precharge length wrong");
    a_refresh_ends: assert property ($rose(b2 == BS_REFRESH)
        |=> b2 == BS_IDLE) else $error("bank refresh length wrong");
    a_auto_pre_ends: assert property ($rose(b2 == BS_AUTO_PRE)
        |=> b2 == BS_IDLE) else $error("auto precharge length wrong");
    a_act_mrr_len: assert property ($rose(b2 == BS_ACT_MRR)
        |-> (b2 == BS_ACT_MRR) [*2] ##1 b2 == BS_ACTIVE)
        else $error("active register read length wrong");
    a_ab_refresh_len: assert property ($rose(dev_state == DS_REFRESH_AB)
        |-> (dev_state == DS_REFRESH_AB) [*2] ##1 dev_state == DS_BANKS)
        else $error("all-bank refresh length wrong");
    a_mr_write_len: assert property ($rose(dev_state == DS_MR_WRITE)
        |-> (dev_state == DS_MR_WRITE) [*5] ##1 dev_state == DS_BANKS)
        else $error("register write length wrong");
    a_mr_read_len: assert property ($rose(mode_register_read)
        |-> mode_register_read [*2] ##1 dev_state == DS_BANKS)
        else $error("register read length wrong");
    a_prech_all_end: assert property ($rose(dev_state == DS_PRECH_ALL)
        |=> dev_state == DS_BANKS && idle_all)
        else $error("precharge all did not leave banks idle");
    a_bst_to_active: assert property (ok && c2_ff.code == CMD_BURST_TERM
        && (b2 == BS_READING || b2 == BS_WRITING) |=> ##[0:1] b2 == BS_ACTIVE)
        else $error("burst terminate did not end burst");
    a_idle_flag: assert property ($rose(dev_state == DS_BANKS && idle_all)
        |=> all_idle) else $error("all idle flag missing");
endmodule

bind sdram_bank_state_tracker tracker_asserts #(
    .NUM_BANKS(NUM_BANKS),
    .CNT_W    (CNT_W)
) chk (
    .clk_sys, .reset, .clk_en, .cmd_valid, .cmd, .burst_done,
    .bank_states, .dev_state, .all_idle, .cmd_illegal
);
`default_nettype wire

//--- verilog/bank_tracker_defs.svh
`ifndef BANK_TRACKER_DEFS_SVH
`define BANK_TRACKER_DEFS_SVH

// timing figures in ns, and derived cycle counts at 100 ns per cycle
`define CLK_PERIOD_NS          100
`define ROW_TO_COLUMN_DELAY_NS 18
`define PRECHARGE_TIME_NS      18
`define PER_BANK_REFRESH_NS    90
`define ALL_BANK_REFRESH_NS    130
`define REGISTER_READ_CYCLES   2
`define REGISTER_WRITE_CYCLES  5
`define CYC_UP(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ROW_TO_COLUMN_CYCLES   `CYC_UP(`ROW_TO_COLUMN_DELAY_NS)
`define PRECHARGE_CYCLES       `CYC_UP(`PRECHARGE_TIME_NS)
`define PER_BANK_REFRESH_CYCLES `CYC_UP(`PER_BANK_REFRESH_NS)
`define ALL_BANK_REFRESH_CYCLES `CYC_UP(`ALL_BANK_REFRESH_NS)
// exit time after power-down, in cycles
`define POWER_DOWN_EXIT_CYCLES 2

`endif

//--- verilog/bank_tracker_pkg.sv
package bank_tracker_pkg;

    // command codes on the decoded command port
    typedef enum logic [3:0] {
        CMD_NOP        = 4'h0,
        CMD_ACTIVATE   = 4'h1,
        CMD_READ       = 4'h2,
        CMD_WRITE      = 4'h3,
        CMD_BURST_TERM = 4'h4,
        CMD_PRECHARGE  = 4'h5,
        CMD_PRECH_ALL  = 4'h6,
        CMD_REFRESH_PB = 4'h7,
        CMD_REFRESH_AB = 4'h8,
        CMD_MR_READ    = 4'h9,
        CMD_MR_WRITE   = 4'hA,
        CMD_RESET      = 4'hB
    } cmd_code_t;

    // per-bank state, one-hot
    typedef enum logic [8:0] {
        BS_IDLE       = 9'h001,
        BS_ACTIVATING = 9'h002,
        BS_ACTIVE     = 9'h004,
        BS_READING    = 9'h008,
        BS_WRITING    = 9'h010,
        BS_AUTO_PRE   = 9'h020,
        BS_PRECHARGE  = 9'h040,
        BS_REFRESH    = 9'h080,
        BS_ACT_MRR    = 9'h100
    } bank_state_t;

    // device-wide state, one-hot
    typedef enum logic [7:0] {
        DS_POWER_ON   = 8'h01,
        DS_RESETTING  = 8'h02,
        DS_BANKS      = 8'h04,
        DS_REFRESH_AB = 8'h08,
        DS_IDLE_MRR   = 8'h10,
        DS_RESET_MRR  = 8'h20,
        DS_MR_WRITE   = 8'h40,
        DS_PRECH_ALL  = 8'h80
    } dev_state_t;

    // one command as registered at a rising edge
    typedef struct packed {
        cmd_code_t  code;
        logic [2:0] bank;
        logic       auto_precharge;
        logic       reset_write;
    } sdram_cmd_t;

endpackage

//--- verilog/sdram_bank_state_tracker.sv
`timescale 1ns/1ns
`default_nettype none
`include "bank_tracker_defs.svh"

module sdram_bank_state_tracker
    import bank_tracker_pkg::*;
#(
    parameter int NUM_BANKS = 8,
    parameter int CNT_W     = 8
) (
    input  wire logic                 clk_sys,
    input  wire logic                 reset,
    input  wire logic                 clk_en,
    input  wire logic                 cmd_valid,
    input  wire sdram_cmd_t           cmd,
    input  wire logic                 burst_done,
    output logic [NUM_BANKS*9-1:0]    bank_states,
    output dev_state_t                dev_state,
    output logic                      all_idle,
    output logic                      cmd_illegal
);

    // ------------------------------------------------------------
    // parameter checks
    // ------------------------------------------------------------
    if (NUM_BANKS != 8) begin : g_bad_banks
        $error("bank count must be 8");
    end
    if (CNT_W < 4) begin : g_bad_width
        $error("counter width too small");
    end

    localparam logic [CNT_W-1:0] RCD_CYC =
        CNT_W'(`ROW_TO_COLUMN_CYCLES);
    localparam logic [CNT_W-1:0] RP_CYC  = CNT_W'(`PRECHARGE_CYCLES);
    localparam logic [CNT_W-1:0] RFPB_CYC =
        CNT_W'(`PER_BANK_REFRESH_CYCLES);
    localparam logic [CNT_W-1:0] RFAB_CYC =
        CNT_W'(`ALL_BANK_REFRESH_CYCLES);
    localparam logic [CNT_W-1:0] MRR_CYC = CNT_W'(`REGISTER_READ_CYCLES);
    localparam logic [CNT_W-1:0] MRW_CYC = CNT_W'(`REGISTER_WRITE_CYCLES);
    localparam logic [CNT_W-1:0] XP_CYC  =
        CNT_W'(`POWER_DOWN_EXIT_CYCLES);

    // ------------------------------------------------------------
    // pin synchronisers for clock enable and command
    // ------------------------------------------------------------
    logic       cke_s1_ff;
    logic       cke_s2_ff;
    logic       cke_prev_ff;
    logic       vld_s1_ff;
    logic       vld_s2_ff;
    sdram_cmd_t cmd_s1_ff;
    sdram_cmd_t cmd_s2_ff;
    logic       done_s1_ff;
    logic       done_s2_ff;
    logic [CNT_W-1:0] exit_cnt_ff;

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            cke_s1_ff   <= 1'b0;
            cke_s2_ff   <= 1'b0;
            cke_prev_ff <= 1'b0;
            vld_s1_ff   <= 1'b0;
            vld_s2_ff   <= 1'b0;
            cmd_s1_ff   <= '0;
            cmd_s2_ff   <= '0;
            done_s1_ff  <= 1'b0;
            done_s2_ff  <= 1'b0;
        end else begin
            cke_s1_ff   <= clk_en;
            cke_s2_ff   <= cke_s1_ff;
            cke_prev_ff <= cke_s2_ff;
            vld_s1_ff   <= cmd_valid;
            vld_s2_ff   <= vld_s1_ff;
            cmd_s1_ff   <= cmd;
            cmd_s2_ff   <= cmd_s1_ff;
            done_s1_ff  <= burst_done;
            done_s2_ff  <= done_s1_ff;
        end
    end

    // exit timer: reloads while clock enable low
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset)
            exit_cnt_ff <= '0;
        else if (!cke_s2_ff)
            exit_cnt_ff <= XP_CYC;
        else if (exit_cnt_ff != '0)
            exit_cnt_ff <= exit_cnt_ff - 1'b1;
    end

    // command takes effect only with both enables high and exit met
    wire step    = cke_s2_ff && cke_prev_ff &&
                   (exit_cnt_ff == '0);
    wire take    = step && vld_s2_ff;
    wire [3:0] c = cmd_s2_ff.code;
    wire [2:0] tb = cmd_s2_ff.bank;

    // ------------------------------------------------------------
    // device-wide state
    // ------------------------------------------------------------
    dev_state_t       dev_ff;
    dev_state_t       nxt_dev;
    logic [CNT_W-1:0] dcnt_ff;
    logic [CNT_W-1:0] nxt_dcnt;
    logic [2:0]       last_bank_ff;
    logic             any_busy;

    bank_state_t      bst_ff  [NUM_BANKS];
    logic [CNT_W-1:0] bcnt_ff [NUM_BANKS];

    // true when a bank is fully idle
    function automatic logic is_idle(input bank_state_t s);
        return s == BS_IDLE;
    endfunction

    // true for states valid for precharge
    function automatic logic can_pre(input bank_state_t s);
        return s inside {BS_IDLE, BS_ACTIVE, BS_READING, BS_WRITING};
    endfunction

    logic all_idle_w;
    logic all_can_pre;
    always_comb begin
        all_idle_w  = 1'b1;
        all_can_pre = 1'b1;
        for (int i = 0; i < NUM_BANKS; i++) begin
            all_idle_w  = all_idle_w & is_idle(bst_ff[i]);
            all_can_pre = all_can_pre & can_pre(bst_ff[i]);
        end
    end

    wire dev_timer_end = (dcnt_ff == 1);
    wire banks_mode    = (dev_ff == DS_BANKS);
    wire sel_state_ok  = banks_mode && all_idle_w;

    // device transitions
    always_comb begin
        nxt_dev  = dev_ff;
        nxt_dcnt = dcnt_ff;
        if (step && dcnt_ff != '0)
            nxt_dcnt = dcnt_ff - 1'b1;
        case (dev_ff)
            DS_POWER_ON: begin
                if (take && c == CMD_MR_WRITE && cmd_s2_ff.reset_write)
                    nxt_dev = DS_RESETTING;
            end
            DS_RESETTING: begin
                if (take && c == CMD_MR_READ) begin
                    nxt_dev  = DS_RESET_MRR;
                    nxt_dcnt = MRR_CYC;
                end else if (take && c == CMD_MR_WRITE) begin
                    nxt_dev  = DS_MR_WRITE;
                    nxt_dcnt = MRW_CYC;
                end
            end
            DS_BANKS: begin
                if (take && sel_state_ok) begin
                    case (c)
                        CMD_REFRESH_AB: begin
                            nxt_dev  = DS_REFRESH_AB;
                            nxt_dcnt = RFAB_CYC;
                        end
                        CMD_MR_WRITE: begin
                            nxt_dev  = cmd_s2_ff.reset_write ?
                                DS_RESETTING : DS_MR_WRITE;
                            nxt_dcnt = MRW_CYC;
                        end
                        CMD_MR_READ: begin
                            nxt_dev  = DS_IDLE_MRR;
                            nxt_dcnt = MRR_CYC;
                        end
                        CMD_RESET:
                            nxt_dev = DS_RESETTING;
                        default: ;
                    endcase
                end
                if (take && c == CMD_PRECH_ALL && all_can_pre) begin
                    nxt_dev  = DS_PRECH_ALL;
                    nxt_dcnt = RP_CYC;
                end
            end
            DS_REFRESH_AB, DS_IDLE_MRR, DS_RESET_MRR, DS_MR_WRITE,
            DS_PRECH_ALL: begin
                if (step && dev_timer_end)
                    nxt_dev = DS_BANKS;
            end
            default: nxt_dev = DS_POWER_ON;
        endcase
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            dev_ff  <= DS_POWER_ON;
            dcnt_ff <= '0;
        end else begin
            dev_ff  <= nxt_dev;
            dcnt_ff <= nxt_dcnt;
        end
    end

    // ------------------------------------------------------------
    // per-bank state machines
    // ------------------------------------------------------------
    logic [NUM_BANKS-1:0] bad_w;

    for (genvar g = 0; g < NUM_BANKS; g++) begin : g_bank
        bank_state_t      nxt_bs;
        logic [CNT_W-1:0] nxt_bc;
        logic             hit;
        logic             bad;
        logic             tend;

        assign hit  = take && banks_mode && (tb == 3'(g));
        assign tend = step && (bcnt_ff[g] == 1);
        assign bad_w[g] = bad;

        always_comb begin
            nxt_bs = bst_ff[g];
            nxt_bc = bcnt_ff[g];
            bad    = 1'b0;
            if (step && bcnt_ff[g] != '0)
                nxt_bc = bcnt_ff[g] - 1'b1;
            case (bst_ff[g])
                BS_IDLE: begin
                    if (hit && c == CMD_ACTIVATE) begin
                        nxt_bs = BS_ACTIVATING;
                        nxt_bc = RCD_CYC;
                    end else if (hit && c == CMD_REFRESH_PB) begin
                        nxt_bs = BS_REFRESH;
                        nxt_bc = RFPB_CYC;
                    end else if (hit && c == CMD_PRECHARGE) begin
                        nxt_bs = BS_PRECHARGE;
                        nxt_bc = RP_CYC;
                    end
                end
                BS_ACTIVE, BS_READING, BS_WRITING: begin
                    if (hit && (c == CMD_READ || c == CMD_WRITE)) begin
                        // auto-precharge picked per command
                        if (cmd_s2_ff.auto_precharge) begin
                            nxt_bs = BS_AUTO_PRE;
                            nxt_bc = RP_CYC;
                        end else begin
                            nxt_bs = (c == CMD_READ) ?
                                BS_READING : BS_WRITING;
                        end
                        bad = bst_ff[g] != BS_ACTIVE && !done_s2_ff &&
                            (bst_ff[g] == BS_READING) !=
                            (c == CMD_READ);
                    end else if (hit && c == CMD_PRECHARGE) begin
                        nxt_bs = BS_PRECHARGE;
                        nxt_bc = RP_CYC;
                    end else if (hit && c == CMD_MR_READ &&
                                 bst_ff[g] == BS_ACTIVE) begin
                        nxt_bs = BS_ACT_MRR;
                        nxt_bc = MRR_CYC;
                    end
                    if (take && banks_mode && c == CMD_BURST_TERM &&
                        last_bank_ff == 3'(g) &&
                        bst_ff[g] != BS_ACTIVE)
                        nxt_bs = BS_ACTIVE;
                    if (step && done_s2_ff && bst_ff[g] != BS_ACTIVE &&
                        !(hit && (c == CMD_READ || c == CMD_WRITE)))
                        nxt_bs = BS_ACTIVE;
                end
                BS_ACTIVATING: begin
                    bad = hit;
                    if (tend)
                        nxt_bs = BS_ACTIVE;
                end
                BS_REFRESH, BS_PRECHARGE, BS_AUTO_PRE: begin
                    bad = hit;
                    if (tend)
                        nxt_bs = BS_IDLE;
                end
                BS_ACT_MRR: begin
                    bad = hit;
                    if (tend)
                        nxt_bs = BS_ACTIVE;
                end
                default: nxt_bs = BS_IDLE;
            endcase
            if (hit && c == CMD_REFRESH_PB && !is_idle(bst_ff[g]))
                bad = 1'b1;
            // precharge-all moves every bank together
            if (banks_mode && nxt_dev == DS_PRECH_ALL) begin
                nxt_bs = BS_PRECHARGE;
                nxt_bc = RP_CYC;
            end
        end

        always_ff @(posedge clk_sys or posedge reset) begin
            if (reset) begin
                bst_ff[g]  <= BS_IDLE;
                bcnt_ff[g] <= '0;
            end else begin
                bst_ff[g]  <= nxt_bs;
                bcnt_ff[g] <= nxt_bc;
            end
        end

        assign bank_states[g*9 +: 9] = bst_ff[g];
    end

    // latest read or write bank, target of burst terminate
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset)
            last_bank_ff <= '0;
        else if (take && (c == CMD_READ || c == CMD_WRITE))
            last_bank_ff <= tb;
    end

    // ------------------------------------------------------------
    // illegal command flag, one cycle
    // ------------------------------------------------------------
    wire wide_cmd = c inside {CMD_REFRESH_AB, CMD_MR_WRITE, CMD_RESET};
    always_comb begin
        any_busy = |bad_w;
        if (take && !banks_mode && dev_ff != DS_POWER_ON &&
            dev_ff != DS_RESETTING && c != CMD_NOP)
            any_busy = 1'b1;
        if (take && banks_mode && wide_cmd && !all_idle_w)
            any_busy = 1'b1;
        if (take && banks_mode && c == CMD_PRECH_ALL && !all_can_pre)
            any_busy = 1'b1;
    end

    logic illegal_ff;
    logic idle_ff;
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            illegal_ff <= 1'b0;
            idle_ff    <= 1'b0;
        end else begin
            illegal_ff <= any_busy;
            idle_ff    <= banks_mode && all_idle_w;
        end
    end

    assign dev_state   = dev_ff;
    assign all_idle    = idle_ff;
    assign cmd_illegal = illegal_ff;

endmodule
`default_nettype wire
